// ### system_config_regs.vh
// Constants for the system configuration register bank: field positions,
// masks, reset values and address windows.
// Assumes a 16-bit register reached through a dedicated CPU register port.
//
// Functional notes
// - Share field gates external master peripheral access
// - Visible field mirrors peripheral accesses on pins
// - Serial port enable selects upper port-4 pins not used for segment address
// - Write config strapped; splits low/high write
// - Clock enable drives system clock on pin
// - Clock output half duty, CPU frequency
// - Clock output forces driver, ignores direction
// - Clock output enable is zero after reset
// - Byte-high disable frees pin; reset from width
// - ROM enable strapped from external-access pin
// - ROM mapping selects segment zero or one
// - Non-segmented mode stacks instruction pointer only
// - Segmented mode stacks segment and instruction pointers
// - Segmented mode is the reset default
// - Interrupt entry/exit stacks segment pointer if segmented
// - Stack size field selects physical stack size
// - Circular stack allows larger virtual stack
// - Register locked after end-of-init instruction
// - Reset value follows port-0 pins during reset
// - Single byte write clears other byte
// - Reserved bits ignore writes, read zero
`ifndef SYSTEM_CONFIG_REGS_VH
`define SYSTEM_CONFIG_REGS_VH

`define SCFG_WIDTH          16
`define SCFG_SHARE_BIT      0
`define SCFG_VISIBLE_BIT    1
`define SCFG_SSP_EN_BIT     2
`define SCFG_WRITE_STROBE_CONFIG_BIT      7
`define SCFG_CLOCK_OUTPUT_ENABLE_BIT      8
`define SCFG_BYTE_HIGH_DISABLE_BIT     9
`define SCFG_ROM_ENABLE_BIT      10
`define SCFG_SEGMENTATION_DISABLE_BIT     11
`define SCFG_ROMMAP_BIT     12
`define SCFG_STK_LSB        13
`define SCFG_STK_MSB        15

// Bits 6..3 are reserved
`define SCFG_IMPL_MASK      16'hff87
`define SCFG_RESET_FIXED    16'h0000

`define SCFG_CLOCK_OUTPUT_ENABLE_RST      1'b0
`define SCFG_SEGMENTATION_DISABLE_RST     1'b0

// ROM window: 32 Kbyte at the start of segment 0 or segment 1
`define ROM_SEG_MSB         23
`define ROM_SEG_LSB         16
`define ROM_OFS_TOP_BIT     15
`define ROM_SEG0            8'h00
`define ROM_SEG1            8'h01

`endif

// ### clock_output_gen.v
// Gated system clock output for the shared port 3 bit 15 pin.
// Assumes ref_clk_i is the CPU clock with a 50 % duty cycle.
`timescale 1ns/1ps
`default_nettype none

module clock_output_gen (
    input  wire ref_clk_i,
    input  wire rst_n_i,
    input  wire enable_i,
    input  wire gpio_out_i,
    input  wire gpio_dir_i,
    output wire pin_out_o,
    output wire pin_oe_o,
    output wire active_o
);

    reg gate_ff;

    // Gate re-timed on the falling edge so the AND never glitches
    always @(negedge ref_clk_i) begin
        if (!rst_n_i) begin
            gate_ff <= 1'b0;
        end else begin
            gate_ff <= enable_i;
        end
    end

    // Full-rate clock, half duty
    // Duty follows the CPU clock itself; no divider stage here.
    wire gated_clk = ref_clk_i & gate_ff;

    assign pin_out_o = enable_i ? gated_clk : gpio_out_i;
    assign pin_oe_o  = enable_i ? 1'b1 : gpio_dir_i;
    assign active_o  = gate_ff;

endmodule // clock_output_gen

`default_nettype wire

// ### system_config_register.v
// System configuration register and the pin and control steering it feeds.
// Assumes the CPU presents one-cycle register writes with byte enables and
// that the strap inputs show the port-0 levels while reset is held.
`timescale 1ns/1ps
`default_nettype none
`include "system_config_regs.vh"

module system_config_register #(
    parameter P4_PINS = 4
) (
    input  wire                   ref_clk_i,
    input  wire                   rst_n_i,
    // Strap levels, valid while rst_n_i is low
    input  wire                   p0h0_strap_i,
    input  wire                   ext_access_strap_i,
    input  wire                   bus_8bit_strap_i,
    // CPU register port
    input  wire                   cfg_sel_i,
    input  wire                   cfg_wr_i,
    input  wire [1:0]             cfg_be_i,
    input  wire [15:0]            cfg_wdata_i,
    output wire [15:0]            cfg_rdata_o,
    output wire                   cfg_wr_taken_o,
    input  wire                   end_of_init_i,
    output wire                   init_locked_o,
    // Extension-bus sharing and visibility
    input  wire                   hold_mode_i,
    input  wire                   ext_extension_bus_req_i,
    output wire                   ext_extension_bus_grant_o,
    input  wire                   extension_bus_access_i,
    input  wire [23:0]            extension_bus_addr_i,
    output wire                   ext_mirror_o,
    output wire [23:0]            ext_mirror_addr_o,
    // Upper port-4 pins
    input  wire [P4_PINS-1:0]     ssp_out_i,
    input  wire [P4_PINS-1:0]     ssp_oe_i,
    input  wire [P4_PINS-1:0]     gpio4_out_i,
    input  wire [P4_PINS-1:0]     gpio4_oe_i,
    input  wire [P4_PINS-1:0]     seg_addr_en_i,
    input  wire [P4_PINS-1:0]     seg_addr_i,
    output wire [P4_PINS-1:0]     p4_out_o,
    output wire [P4_PINS-1:0]     p4_oe_o,
    output wire                   ssp_enable_o,
    // Write strobe and high-byte pins
    input  wire                   wr_n_i,
    input  wire                   bhe_n_i,
    input  wire                   wr_lo_n_i,
    input  wire                   wr_hi_n_i,
    input  wire                   gpio_bhe_out_i,
    input  wire                   gpio_bhe_oe_i,
    output wire                   wr_pin_n_o,
    output wire                   bhe_pin_n_o,
    output wire                   bhe_pin_oe_o,
    // Clock output pin
    input  wire                   p3_15_gpio_out_i,
    input  wire                   p3_15_dir_i,
    output wire                   p3_15_out_o,
    output wire                   p3_15_oe_o,
    output wire                   clock_output_active_o,
    // ROM window decode
    input  wire [23:0]            code_addr_i,
    output wire                   rom_hit_o,
    output wire                   rom_external_o,
    // Stack frame control
    input  wire                   implicit_call_i,
    input  wire                   implicit_ret_i,
    input  wire                   irq_entry_i,
    input  wire                   irq_exit_i,
    output wire                   push_ip_o,
    output wire                   pop_ip_o,
    output wire                   push_csp_o,
    output wire                   pop_csp_o,
    output wire [1:0]             frame_words_o,
    output wire [2:0]             stack_size_o
);

    reg  [15:0] config_ff;
    reg  [15:0] nxt_config;
    reg         lock_ff;
    reg         mirror_ff;
    reg  [23:0] mirror_addr_ff;

    wire        wr_req;
    wire        wr_ok;
    wire [15:0] byte_merge;
    wire [15:0] strap_value;

    wire share_en   = config_ff[`SCFG_SHARE_BIT];
    wire visible_en = config_ff[`SCFG_VISIBLE_BIT];
    wire ssp_en     = config_ff[`SCFG_SSP_EN_BIT];
    wire write_strobe_config      = config_ff[`SCFG_WRITE_STROBE_CONFIG_BIT];
    wire clock_output_enable      = config_ff[`SCFG_CLOCK_OUTPUT_ENABLE_BIT];
    wire byte_high_disable     = config_ff[`SCFG_BYTE_HIGH_DISABLE_BIT];
    wire rom_enable      = config_ff[`SCFG_ROM_ENABLE_BIT];
    wire segmentation_disable     = config_ff[`SCFG_SEGMENTATION_DISABLE_BIT];
    wire rommap     = config_ff[`SCFG_ROMMAP_BIT];

    assign wr_req = cfg_sel_i & cfg_wr_i & (|cfg_be_i);

    // Lock after end-of-init
    // A write in the same cycle as the end-of-init pulse is refused too,
    // so no configuration can slip past the lock.
    // Late writes silently dropped
    assign wr_ok  = wr_req & ~lock_ff & ~end_of_init_i;

    assign byte_merge[7:0]  = cfg_be_i[0] ? cfg_wdata_i[7:0]  : 8'h00;
    assign byte_merge[15:8] = cfg_be_i[1] ? cfg_wdata_i[15:8] : 8'h00;

    // Reset value from port-0 pins
    // Fixed fields take constants; strapped fields take pin levels.
    assign strap_value = `SCFG_RESET_FIXED
        | ({15'h0000, p0h0_strap_i} << `SCFG_WRITE_STROBE_CONFIG_BIT)
        | ({15'h0000, bus_8bit_strap_i} << `SCFG_BYTE_HIGH_DISABLE_BIT)
        | ({15'h0000, ext_access_strap_i} << `SCFG_ROM_ENABLE_BIT)
        | ({15'h0000, `SCFG_CLOCK_OUTPUT_ENABLE_RST} << `SCFG_CLOCK_OUTPUT_ENABLE_BIT)
        | ({15'h0000, `SCFG_SEGMENTATION_DISABLE_RST} << `SCFG_SEGMENTATION_DISABLE_BIT);

    always @* begin
        nxt_config = config_ff;
        if (wr_ok) begin
            nxt_config = byte_merge & `SCFG_IMPL_MASK;
        end
    end

    // Reset is synchronous, so sampling the straps in the reset branch
    // captures the pin levels on the last edge before release.
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            config_ff <= strap_value & `SCFG_IMPL_MASK;
        end else begin
            config_ff <= nxt_config;
        end
    end

    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            lock_ff <= 1'b0;
        end else if (end_of_init_i) begin
            lock_ff <= 1'b1;
        end
    end

    assign cfg_rdata_o    = config_ff & `SCFG_IMPL_MASK;
    assign cfg_wr_taken_o = wr_ok;
    assign init_locked_o  = lock_ff;

    assign ext_extension_bus_grant_o = share_en & hold_mode_i & ext_extension_bus_req_i;

    // Mirror peripheral accesses
    // One cycle late; the external cycle is a copy, not the real access.
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            mirror_ff      <= 1'b0;
            mirror_addr_ff <= 24'h000000;
        end else begin
            mirror_ff <= visible_en & extension_bus_access_i;
            if (visible_en & extension_bus_access_i) begin
                mirror_addr_ff <= extension_bus_addr_i;
            end
        end
    end

    assign ext_mirror_o      = mirror_ff;
    assign ext_mirror_addr_o = mirror_addr_ff;

    // Upper port-4 pin steering
    // Segment address use wins over both the port and the serial port.
    genvar gi;
    generate
        for (gi = 0; gi < P4_PINS; gi = gi + 1) begin : g_p4
            assign p4_out_o[gi] = seg_addr_en_i[gi] ? seg_addr_i[gi] :
                                  ssp_en ? ssp_out_i[gi] : gpio4_out_i[gi];
            assign p4_oe_o[gi]  = seg_addr_en_i[gi] ? 1'b1 :
                                  ssp_en ? ssp_oe_i[gi] : gpio4_oe_i[gi];
        end
    endgenerate

    assign ssp_enable_o = ssp_en;

    assign wr_pin_n_o = write_strobe_config ? wr_lo_n_i : wr_n_i;

    // High-byte pin release
    // With the pin released it becomes plain port IO.
    assign bhe_pin_n_o  = byte_high_disable ? gpio_bhe_out_i :
                          (write_strobe_config ? wr_hi_n_i : bhe_n_i);
    assign bhe_pin_oe_o = byte_high_disable ? gpio_bhe_oe_i : 1'b1;

    clock_output_gen u_clock_output_gen (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .enable_i   (clock_output_enable),
        .gpio_out_i (p3_15_gpio_out_i),
        .gpio_dir_i (p3_15_dir_i),
        .pin_out_o  (p3_15_out_o),
        .pin_oe_o   (p3_15_oe_o),
        .active_o   (clock_output_active_o)
    );

    wire [7:0] rom_seg  = rommap ? `ROM_SEG1 : `ROM_SEG0;
    wire       in_rom   = (code_addr_i[`ROM_SEG_MSB:`ROM_SEG_LSB] == rom_seg) &
                          ~code_addr_i[`ROM_OFS_TOP_BIT];
    // Disabled ROM goes external
    // No internal ROM exists, so software is expected to keep both fields
    // at zero; decode still follows the fields as written.
    assign rom_hit_o      = in_rom & rom_enable;
    assign rom_external_o = in_rom & ~rom_enable;

    assign push_ip_o = implicit_call_i | irq_entry_i;
    assign pop_ip_o  = implicit_ret_i | irq_exit_i;
    assign push_csp_o = ~segmentation_disable & (implicit_call_i | irq_entry_i);
    assign pop_csp_o  = ~segmentation_disable & (implicit_ret_i | irq_exit_i);
    assign frame_words_o = segmentation_disable ? 2'd1 : 2'd2;

    // Circular wrap handled by stack logic
    assign stack_size_o = config_ff[`SCFG_STK_MSB:`SCFG_STK_LSB];

endmodule // system_config_register

`default_nettype wire

// ### system_config_register_asserts.sv
// Port checker for the system configuration register bank.
// Assumes one clock domain and a bind onto system_config_register.
`timescale 1ns/1ps
`default_nettype none
module system_config_asserts (
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic [1:0]  cfg_be_i,
    input wire logic        end_of_init_i,
    input wire logic        cfg_wr_taken_o,
    input wire logic        init_locked_o,
    input wire logic [15:0] cfg_rdata_o,
    input wire logic        hold_mode_i,
    input wire logic        ext_extension_bus_req_i,
    input wire logic        ext_extension_bus_grant_o,
    input wire logic        extension_bus_access_i,
    input wire logic        ext_mirror_o,
    input wire logic        push_ip_o,
    input wire logic        push_csp_o,
    input wire logic        p3_15_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence lo_write_s;
        cfg_wr_taken_o && cfg_be_i == 2'h1;
    endsequence
    sequence seen_access_s;
        extension_bus_access_i && cfg_rdata_o[1];
    endsequence
    lock_refuse_a: assert property (
        init_locked_o |-> !cfg_wr_taken_o) else $error("write while locked");
    lock_set_a: assert property (
        end_of_init_i |=> init_locked_o[*2]) else $error("lock not set");
    locked_hold_a: assert property (
        init_locked_o |=> $stable(cfg_rdata_o)) else $error("locked value moved");
    byte_clear_a: assert property (
        lo_write_s |=> cfg_rdata_o[15:8] == 8'h0) else $error("high byte kept");
    share_grant_a: assert property (
        ext_extension_bus_grant_o == (cfg_rdata_o[0] && hold_mode_i && ext_extension_bus_req_i))
        else $error("grant mismatch");
    mirror_echo_a: assert property (
        seen_access_s |=> ext_mirror_o) else $error("access not mirrored");
    mirror_cause_a: assert property (
        ext_mirror_o |-> $past(extension_bus_access_i && cfg_rdata_o[1]))
        else $error("stray mirror pulse");
    csp_gate_a: assert property (
        push_csp_o == (push_ip_o && !cfg_rdata_o[11])) else $error("csp push");
    clk_driver_a: assert property (
        cfg_rdata_o[8] |-> p3_15_oe_o) else $error("clock pin not driven");
endmodule // system_config_asserts

bind system_config_register system_config_asserts chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_be_i(cfg_be_i),
    .end_of_init_i(end_of_init_i), .cfg_wr_taken_o(cfg_wr_taken_o),
    .init_locked_o(init_locked_o), .cfg_rdata_o(cfg_rdata_o),
    .hold_mode_i(hold_mode_i), .ext_extension_bus_req_i(ext_extension_bus_req_i),
    .ext_extension_bus_grant_o(ext_extension_bus_grant_o), .extension_bus_access_i(extension_bus_access_i),
    .ext_mirror_o(ext_mirror_o), .push_ip_o(push_ip_o),
    .push_csp_o(push_csp_o), .p3_15_oe_o(p3_15_oe_o)
);
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the system configuration register bank.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, rst_n, p0h0, ext_acc, b8, sel, wr, eoi, hold, req;
    logic        xacc, call, ret, ient, iexit, wrn, hbn, wrlo, wrhi, gbo;
    logic        gboe, p3o, p3d;
    logic [1:0]  be;
    logic [15:0] wdata, c;
    logic [23:0] xaddr, caddr;
    logic [3:0]  sso, ssoe, g4o, g4oe, sen, sa;
    wire  [15:0] rdata;
    wire  [23:0] maddr;
    wire  [3:0]  p4o, p4oe;
    wire         taken, locked, grant, mirror, son, wpin, bpin, boe, p3out;
    wire         p3oe, cact, romhit, romext, psh, pop, pshc, popc;
    wire  [1:0]  fw;
    wire  [2:0]  stk;
    int          n_errors, checks;
    logic [15:0] cfgs [3] = '{16'h0000, 16'h0183, 16'hff87};

    system_config_register dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .p0h0_strap_i(p0h0),
        .ext_access_strap_i(ext_acc), .bus_8bit_strap_i(b8),
        .cfg_sel_i(sel), .cfg_wr_i(wr), .cfg_be_i(be), .cfg_wdata_i(wdata),
        .cfg_rdata_o(rdata), .cfg_wr_taken_o(taken), .end_of_init_i(eoi),
        .init_locked_o(locked), .hold_mode_i(hold), .ext_extension_bus_req_i(req),
        .ext_extension_bus_grant_o(grant), .extension_bus_access_i(xacc), .extension_bus_addr_i(xaddr),
        .ext_mirror_o(mirror), .ext_mirror_addr_o(maddr), .ssp_out_i(sso),
        .ssp_oe_i(ssoe), .gpio4_out_i(g4o), .gpio4_oe_i(g4oe),
        .seg_addr_en_i(sen), .seg_addr_i(sa), .p4_out_o(p4o), .p4_oe_o(p4oe),
        .ssp_enable_o(son), .wr_n_i(wrn), .bhe_n_i(hbn), .wr_lo_n_i(wrlo),
        .wr_hi_n_i(wrhi), .gpio_bhe_out_i(gbo), .gpio_bhe_oe_i(gboe),
        .wr_pin_n_o(wpin), .bhe_pin_n_o(bpin), .bhe_pin_oe_o(boe),
        .p3_15_gpio_out_i(p3o), .p3_15_dir_i(p3d), .p3_15_out_o(p3out),
        .p3_15_oe_o(p3oe), .clock_output_active_o(cact), .code_addr_i(caddr),
        .rom_hit_o(romhit), .rom_external_o(romext), .implicit_call_i(call),
        .implicit_ret_i(ret), .irq_entry_i(ient), .irq_exit_i(iexit),
        .push_ip_o(psh), .pop_ip_o(pop), .push_csp_o(pshc), .pop_csp_o(popc),
        .frame_words_o(fw), .stack_size_o(stk)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic do_reset(input logic [2:0] straps);
        @(negedge clk);
        rst_n = 1'h0;
        {p0h0, ext_acc, b8} = straps;
        repeat (16) @(negedge clk);
        rst_n = 1'h1;
        #1;
    endtask

    // One-cycle write; end_of_init may ride along in the same cycle
    task automatic wr_reg(input logic [1:0] e, input logic [15:0] d,
                          input logic x, input logic ok);
        @(negedge clk);
        {sel, wr, eoi, be, wdata} = {2'h3, x, e, d};
        #1 chk(taken, ok);
        @(negedge clk);
        {sel, wr, eoi} = 3'h0;
        #1;
    endtask

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Watchdog so a hang still reaches the verdict
    initial begin
        #200000 n_errors++;
        stop_test();
    end

    initial begin
        {rst_n, sel, wr, eoi, hold, req, xacc, call, ret, ient, iexit} = 11'h069;
        {p0h0, ext_acc, b8, be, wdata, xaddr, caddr} = 69'h0;
        {wrn, hbn, wrlo, wrhi, gbo, gboe, p3o, p3d} = 8'hc8;
        {sso, ssoe, g4o, g4oe, sen, sa} = 24'haf5000;
        do_reset(3'h6);
        chk({locked, rdata}, 17'h00480);
        $display("reset defaults done");
        for (int i = 0; i < 3; i++) begin
            c = cfgs[i];
            wr_reg(2'h3, c, 1'h0, 1'h1);
            {xacc, xaddr, caddr} = {1'h1, 8'h12, c, 7'h0, c[12], 16'h1234};
            @(negedge clk);
            xacc = 1'h0;
            #1 chk(rdata, c & 16'hff87);
            chk(grant, c[0]);
            chk({mirror, maddr}, {c[1], c[1] ? {8'h12, c} : 24'h0});
            chk({son, p4o, p4oe}, {c[2], c[2] ? 8'haf : 8'h50});
            chk({wpin, bpin, boe}, {~c[7], c[9] | ~c[7], ~c[9]});
            chk({p3oe, cact}, {c[8], c[8]});
            chk({romhit, romext}, {c[10], ~c[10]});
            chk({psh, pop, pshc, popc, fw},
                {2'h3, ~c[11], ~c[11], c[11] ? 2'h1 : 2'h2});
            chk(stk, c[15:13]);
            caddr[16] = ~c[12];
            #1 chk({romhit, romext}, 2'h0);
            @(posedge clk);
            #2 chk(p3out, c[8]);
            @(negedge clk);
            #2 chk(p3out, 1'h0);
        end
        $display("mode steering done");
        wr_reg(2'h1, 16'h0105, 1'h0, 1'h1);
        chk(rdata, 16'h0005);
        wr_reg(2'h2, 16'ha5ff, 1'h0, 1'h1);
        chk(rdata, 16'ha500);
        wr_reg(2'h0, 16'hffff, 1'h0, 1'h0);
        chk(rdata, 16'ha500);
        $display("byte writes done");
        wr_reg(2'h3, 16'h1234, 1'h1, 1'h0);
        chk({locked, rdata}, 17'h1a500);
        wr_reg(2'h3, 16'hffff, 1'h0, 1'h0);
        chk(rdata, 16'ha500);
        $display("lock done");
        do_reset(3'h1);
        // Strap ROM enable to zero and check ROMMAP resets to zero, as software must keep them
        chk({locked, rdata}, 17'h00200);
        chk(rdata & 16'h1400, 16'h0000);
        $display("second reset done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
